// >>> rtl/eswi_core.sv
// eswi_core: event flags, global summary, receive pin alert with
// re-alert delay, bus silence detection and go-to-sleep protection.
// assumes events, enables, mode and register port are on clk_sys;
// the wake pin and bus level come from pins and are synchronised.
`timescale 1ns/10ps
module eswi_core
  import eswi_pkg::*;
#(
  parameter int REALERT_DELAY  = REALERT_CYCLES,
  parameter int SILENCE_PERIOD = SILENCE_CYCLES
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  // serial register port
  input  wire logic [7:0]    regAddr,
  input  wire logic          regWrEn,
  input  wire logic [7:0]    regWrData,
  input  wire logic          regRdEn,
  output logic [7:0]         regRdData,
  // events, enables and mode
  input  wire eswi_evt_type  events,
  input  wire eswi_en_type   enables,
  input  wire eswi_mode_type mode,
  // mode command
  input  wire logic          modeCmdValid,
  input  wire logic [2:0]    mode_command_field,
  output logic               sleepEnter,
  output logic               standbyEnter,
  output logic               wakeToStandby,
  // pins
  input  wire logic          wakePin,
  input  wire logic          busLevel,
  output logic               rxdHigh,
  output logic               inhibit_output
);

  logic [7:0] sysFlags_reg, sysFlags_next;
  logic [7:0] trxFlags_reg, trxFlags_next;
  logic [7:0] wakeFlags_reg, wakeFlags_next;
  logic [7:0] rdData_reg, rdData_next;
  logic       rxdHigh_reg, rxdHigh_next;
  logic       inhibit_reg, inhibit_next;
  logic       sleep_reg, sleep_next;
  logic       standby_reg, standby_next;
  logic       wake_reg, wake_next;
  logic [2:0] wakeSync_reg, wakeSync_next;
  logic [2:0] busSync_reg, busSync_next;
  logic       silStarted_reg, silStarted_next;
  logic [7:0] sysSet, trxSet, wakeSet;
  logic [7:0] globalNow;
  logic       clearWrite, anyPending, alertArea, sleepCmd, safeSleep;
  logic       rearmRunning, rearmExpire;
  logic       silRunning, silExpire, busActivity;
  logic       wakeRiseEdge, wakeFallEdge;

  // true when a write lands on a flag register with a clearing one
  function automatic logic clears(input logic [7:0] a,
                                  input logic [7:0] d);
    return (a == ADDR_SYS  && |(d & SYS_MASK)) ||
           (a == ADDR_TRX  && |(d & TRX_MASK)) ||
           (a == ADDR_WAKE && |(d & WAKE_MASK));
  endfunction

  // pin synchronisers: stage 0 feeds only stage 1
  always_comb begin
    wakeSync_next = {wakeSync_reg[1:0], wakePin};
    busSync_next  = {busSync_reg[1:0], busLevel};
  end
  assign wakeRiseEdge = wakeSync_reg[1] & ~wakeSync_reg[2];
  assign wakeFallEdge = ~wakeSync_reg[1] & wakeSync_reg[2];
  assign busActivity  = busSync_reg[1] ^ busSync_reg[2];

  // silence timer restarts on every bus edge and once after reset
  assign silStarted_next = 1'b1;
  eswi_delay_timer #(
    .WIDTH (SILENCE_W),
    .LOAD  (SILENCE_W'(SILENCE_PERIOD))
  ) u_silence (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .start   (busActivity | ~silStarted_reg),
    .running (silRunning),
    .expire  (silExpire)
  );

  // re-alert delay timer, restarted by each clearing write
  assign clearWrite = regWrEn && clears(regAddr, regWrData);
  eswi_delay_timer #(
    .WIDTH (REALERT_W),
    .LOAD  (REALERT_W'(REALERT_DELAY))
  ) u_realert (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .start   (clearWrite),
    .running (rearmRunning),
    .expire  (rearmExpire)
  );

  // event sets, gated by capture enables except power-on and PN frame error, which are always captured
  always_comb begin
    sysSet  = '0;
    trxSet  = '0;
    wakeSet = '0;
    sysSet[SYS_PWRON]  = events.powerOnExit;
    sysSet[SYS_HOT]    = events.overtempWarn & enables.overtempEn
                         & mode.modeNormal;
    sysSet[SYS_SFAIL]  = events.serialFail & enables.serialFailEn;
    trxSet[TRX_PNFD]   = events.pnFrameError;
    trxSet[TRX_QUIET]  = silExpire & enables.silenceEn;
    trxSet[TRX_FAIL]   = enables.canFailEn & mode.modeNormal
                         & mode.canActive & (events.txdClamped
                         | (events.vccUnder
                         & mode.transceiver_mode_control == TMC_ACTIVE));
    trxSet[TRX_WAKE]   = events.canWakeup & enables.canWakeEn;
    wakeSet[WAK_RISE]  = wakeRiseEdge & enables.wakeRiseEn;
    wakeSet[WAK_FALL]  = wakeFallEdge & enables.wakeFallEn;
  end

  // write-one-to-clear flags, a set in the same cycle wins
  always_comb begin
    sysFlags_next  = sysFlags_reg;
    trxFlags_next  = trxFlags_reg;
    wakeFlags_next = wakeFlags_reg;
    if (regWrEn && regAddr == ADDR_SYS) begin
      sysFlags_next = sysFlags_reg & ~(regWrData & SYS_MASK);
    end
    if (regWrEn && regAddr == ADDR_TRX) begin
      trxFlags_next = trxFlags_reg & ~(regWrData & TRX_MASK);
    end
    if (regWrEn && regAddr == ADDR_WAKE) begin
      wakeFlags_next = wakeFlags_reg & ~(regWrData & WAKE_MASK);
    end
    if (events.underSleep) begin
      sysFlags_next[SYS_PWRON] = 1'b0;
    end
    sysFlags_next  = (sysFlags_next | sysSet) & SYS_MASK;
    trxFlags_next  = (trxFlags_next | trxSet) & TRX_MASK;
    wakeFlags_next = (wakeFlags_next | wakeSet) & WAKE_MASK;
  end

  // global summary of the three groups
  always_comb begin
    globalNow           = '0;
    globalNow[GLB_WAKE] = |wakeFlags_reg;
    globalNow[GLB_TRX]  = |trxFlags_reg;
    globalNow[GLB_SYS]  = |sysFlags_reg;
  end
  assign anyPending = |globalNow;

  // read mux; reading has no side effect on the flags
  always_comb begin
    rdData_next = rdData_reg;
    if (regRdEn) begin
      case (regAddr)
        ADDR_GLOBAL: rdData_next = globalNow;
        ADDR_SYS:    rdData_next = sysFlags_reg;
        ADDR_TRX:    rdData_next = trxFlags_reg;
        ADDR_WAKE:   rdData_next = wakeFlags_reg;
        default:     rdData_next = '0;
      endcase
    end
  end

  // receive pin alert, held off by a clear and the running timer
  assign alertArea = mode.canOffline | mode.modeStandby;
  always_comb begin
    rxdHigh_next = 1'b1;
    if (alertArea && anyPending && !rearmRunning && !clearWrite) begin
      rxdHigh_next = 1'b0;
    end
  end

  // sleep protection and wake from sleep
  assign sleepCmd  = modeCmdValid && mode_command_field == CMD_SLEEP;
  assign safeSleep = (enables.canWakeEn | enables.wakeRiseEn
                      | enables.wakeFallEn) & ~anyPending;
  always_comb begin
    sleep_next   = sleepCmd & safeSleep;
    standby_next = sleepCmd & ~safeSleep;
    wake_next    = mode.modeSleep
                   & |(sysSet & ~(8'h1 << SYS_SFAIL) | trxSet | wakeSet);
    inhibit_next = inhibit_reg;
    if (sleep_next) begin
      inhibit_next = 1'b0;
    end
    if (wake_next) begin
      inhibit_next = 1'b1;
    end
  end

  // all state registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sysFlags_reg   <= FLAGS_RST;
      trxFlags_reg   <= FLAGS_RST;
      wakeFlags_reg  <= FLAGS_RST;
      rdData_reg     <= '0;
      rxdHigh_reg    <= 1'b1;
      inhibit_reg    <= 1'b1;
      sleep_reg      <= 1'b0;
      standby_reg    <= 1'b0;
      wake_reg       <= 1'b0;
      wakeSync_reg   <= '0;
      busSync_reg    <= '0;
      silStarted_reg <= 1'b0;
    end else begin
      sysFlags_reg   <= sysFlags_next;
      trxFlags_reg   <= trxFlags_next;
      wakeFlags_reg  <= wakeFlags_next;
      rdData_reg     <= rdData_next;
      rxdHigh_reg    <= rxdHigh_next;
      inhibit_reg    <= inhibit_next;
      sleep_reg      <= sleep_next;
      standby_reg    <= standby_next;
      wake_reg       <= wake_next;
      wakeSync_reg   <= wakeSync_next;
      busSync_reg    <= busSync_next;
      silStarted_reg <= silStarted_next;
    end
  end

  // outputs straight from flip-flops
  assign regRdData      = rdData_reg;
  assign rxdHigh        = rxdHigh_reg;
  assign inhibit_output = inhibit_reg;
  assign sleepEnter     = sleep_reg;
  assign standbyEnter   = standby_reg;
  assign wakeToStandby  = wake_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_alert_cause;
    !rxdHigh_reg |-> $past(alertArea && anyPending && !rearmRunning);
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("receive pin low without pending offline event");

  property p_clear_release;
    clearWrite |=> rxdHigh_reg && rearmRunning;
  endproperty
  a_clear_release: assert property (p_clear_release)
    else $error("clear did not release pin and start timer");

  property p_hold_while_timer;
    rearmRunning |=> rxdHigh_reg;
  endproperty
  a_hold_while_timer: assert property (p_hold_while_timer)
    else $error("pin pulled low while re-alert timer runs");

  property p_realert;
    rearmExpire && alertArea && anyPending && !clearWrite
      |=> !rxdHigh_reg;
  endproperty
  a_realert: assert property (p_realert)
    else $error("pending events not re-alerted at expiry");

  property p_quiet_expiry;
    rearmExpire && !anyPending |=> rxdHigh_reg;
  endproperty
  a_quiet_expiry: assert property (p_quiet_expiry)
    else $error("pin low at expiry with nothing pending");

  property p_read_trx;
    regRdEn && regAddr == ADDR_TRX |=> regRdData == $past(trxFlags_reg);
  endproperty
  a_read_trx: assert property (p_read_trx)
    else $error("transceiver flags read back wrong");

  property p_sleep_guard;
    sleepCmd && !safeSleep |=> standbyEnter && !sleepEnter;
  endproperty
  a_sleep_guard: assert property (p_sleep_guard)
    else $error("unsafe sleep command not turned to standby");

  property p_w1c_wake;
    regWrEn && regAddr == ADDR_WAKE && regWrData[WAK_FALL]
      && !wakeSet[WAK_FALL] |=> !wakeFlags_reg[WAK_FALL];
  endproperty
  a_w1c_wake: assert property (p_w1c_wake)
    else $error("falling edge flag not cleared by one");

  property p_set_wins;
    wakeSet[WAK_RISE] |=> wakeFlags_reg[WAK_RISE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("rising edge event lost");

  property p_global;
    regRdEn && regAddr == ADDR_GLOBAL
      |=> regRdData[GLB_WAKE] == $past(|wakeFlags_reg)
          && regRdData[GLB_SYS] == $past(|sysFlags_reg);
  endproperty
  a_global: assert property (p_global)
    else $error("global summary does not match groups");

  property p_po_cleared;
    events.underSleep && !events.powerOnExit |=> !sysFlags_reg[SYS_PWRON];
  endproperty
  a_po_cleared: assert property (p_po_cleared)
    else $error("power-on flag survived forced sleep");

  property p_cf_armed;
    $rose(trxFlags_reg[TRX_FAIL])
      |-> $past(mode.modeNormal && mode.canActive && enables.canFailEn);
  endproperty
  a_cf_armed: assert property (p_cf_armed)
    else $error("CAN failure flagged outside normal active mode");

  property p_inhibit;
    wake_next |=> inhibit_output && wakeToStandby;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("sleep wake did not raise inhibit");

  c_realert: cover property (clearWrite ##1 rearmRunning [*2]
                             ##[1:100] !rxdHigh_reg);
  c_sleep_ok: cover property (sleepCmd && safeSleep ##1 sleepEnter);
  c_wake: cover property (wakeToStandby ##1 inhibit_output);
  c_silence: cover property (trxSet[TRX_QUIET]);

endmodule

// >>> rtl/eswi_delay_timer.sv
// eswi_delay_timer: loadable down counter with running level and
// one-cycle expiry pulse.
// assumes start comes from logic on clk_sys.
`timescale 1ns/10ps
module eswi_delay_timer #(
  parameter int         WIDTH = 12,
  parameter logic [WIDTH-1:0] LOAD = WIDTH'(1)
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // control
  input  wire logic start,
  // status
  output logic      running,
  output logic      expire
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             run_reg;
  logic             run_next;
  logic             exp_reg;
  logic             exp_next;

  // restart on start, count down while running
  always_comb begin
    count_next = count_reg;
    run_next   = run_reg;
    exp_next   = 1'b0;
    if (start) begin
      count_next = LOAD;
      run_next   = 1'b1;
    end else if (run_reg) begin
      if (count_reg <= WIDTH'(1)) begin
        run_next = 1'b0;
        exp_next = 1'b1;
      end else begin
        count_next = count_reg - WIDTH'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
      exp_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      run_reg   <= run_next;
      exp_reg   <= exp_next;
    end
  end

  assign running = run_reg;
  assign expire  = exp_reg;

endmodule

// >>> rtl/eswi_pkg.sv
// eswi_pkg: register map, field positions, timing and carrier types
// for the event status and wake signalling unit.
// assumes one 100 MHz system clock and a byte-wide register port.
package eswi_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS      = 10;
  // bus silence timeout, plain default in ns
  localparam int SILENCE_TIMEOUT_NS = 1000000;
  localparam int SILENCE_CYCLES     = SILENCE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int SILENCE_W          = 17;
  // re-alert delay in clock cycles, plain default
  localparam int REALERT_CYCLES     = 50;
  localparam int REALERT_W          = 12;

  // register offsets
  localparam logic [7:0] ADDR_GLOBAL = 8'h60;
  localparam logic [7:0] ADDR_SYS    = 8'h61;
  localparam logic [7:0] ADDR_TRX    = 8'h63;
  localparam logic [7:0] ADDR_WAKE   = 8'h64;

  // global summary bits
  localparam int GLB_SYS  = 0;
  localparam int GLB_TRX  = 2;
  localparam int GLB_WAKE = 3;
  // system flag bits
  localparam int SYS_SFAIL = 1;
  localparam int SYS_HOT   = 2;
  localparam int SYS_PWRON = 4;
  // transceiver flag bits
  localparam int TRX_WAKE  = 0;
  localparam int TRX_FAIL  = 1;
  localparam int TRX_QUIET = 4;
  localparam int TRX_PNFD  = 5;
  // wake pin flag bits
  localparam int WAK_FALL = 0;
  localparam int WAK_RISE = 1;

  // writable masks and reset values
  localparam logic [7:0] SYS_MASK   = 8'h16;
  localparam logic [7:0] TRX_MASK   = 8'h33;
  localparam logic [7:0] WAKE_MASK  = 8'h03;
  localparam logic [7:0] FLAGS_RST  = 8'h00;

  // mode command code and transceiver mode control code
  localparam logic [2:0] CMD_SLEEP  = 3'h1;
  localparam logic [1:0] TMC_ACTIVE = 2'h1;

  // event pulses from neighbouring logic on clk_sys
  typedef struct packed {
    logic powerOnExit;
    logic overtempWarn;
    logic serialFail;
    logic pnFrameError;
    logic canWakeup;
    logic txdClamped;
    logic vccUnder;
    logic underSleep;
  } eswi_evt_type;

  // capture enables
  typedef struct packed {
    logic overtempEn;
    logic serialFailEn;
    logic silenceEn;
    logic canFailEn;
    logic canWakeEn;
    logic wakeRiseEn;
    logic wakeFallEn;
  } eswi_en_type;

  // current device mode
  typedef struct packed {
    logic       modeNormal;
    logic       modeStandby;
    logic       modeSleep;
    logic       canOffline;
    logic       canActive;
    logic [1:0] transceiver_mode_control;
  } eswi_mode_type;

endpackage

// >>> testbench/eswi_host_model.sv
// eswi_host_model: host side of the byte register port.
// assumes strobes are taken on rising edges of clk_sys.
`timescale 1ns/10ps
module eswi_host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic [7:0]      regAddr,
  output logic            regWrEn,
  output logic [7:0]      regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  // idle port at time zero
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // one write strobe; idle lines then show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
    #1;
  endtask

  // one read strobe; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask

  // clear only the flags that the last read showed set
  task automatic clear_seen(input logic [7:0] a);
    logic [7:0] d;
    rd(a, d);
    wr(a, d);
  endtask
endmodule

// >>> testbench/tb.sv
// tb: self-checking bench for eswi_core driven through a host model.
// assumes shortened silence and re-alert counts set below.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end end
module tb import eswi_pkg::*; ;
  localparam int RD = 5;
  localparam int SP = 20;
  // stimulus and observed signals
  logic          clk_sys;
  logic          nrst;
  logic [7:0]    regAddr;
  logic          regWrEn;
  logic [7:0]    regWrData;
  logic          regRdEn;
  logic [7:0]    regRdData;
  eswi_evt_type  evt;
  eswi_en_type   en;
  eswi_mode_type md;
  logic          cmdV;
  logic [2:0]    cmd;
  logic          sleepEnter;
  logic          standbyEnter;
  logic          wakeToStandby;
  logic          wakePin;
  logic          busLevel;
  logic          rxdHigh;
  logic          inhibit_output;
  logic [7:0]    d;
  int            err_total = 0;
  int            tests_run = 0;

  eswi_core #(.REALERT_DELAY(RD), .SILENCE_PERIOD(SP)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .events(evt), .enables(en), .mode(md),
    .modeCmdValid(cmdV), .mode_command_field(cmd),
    .sleepEnter(sleepEnter), .standbyEnter(standbyEnter),
    .wakeToStandby(wakeToStandby), .wakePin(wakePin),
    .busLevel(busLevel), .rxdHigh(rxdHigh),
    .inhibit_output(inhibit_output));

  eswi_host_model i_host (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // let n edges pass, then step past them
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one-cycle event pulse, flags visible on return
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_sys);
    evt <= eswi_evt_type'(e);
    @(posedge clk_sys);
    evt <= '0;
    #1;
  endtask

  // read a register and compare
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    `CHK(d, e)
  endtask

  // mode command, answer visible on return
  task automatic mode_cmd(input logic [2:0] c);
    @(posedge clk_sys);
    cmdV <= 1'b1;
    cmd <= c;
    @(posedge clk_sys);
    cmdV <= 1'b0;
    #1;
  endtask

  // verdict and end of run
  task automatic conclude;
    $display("errors %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #100000;
    err_total++;
    conclude;
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    evt = '0;
    en = '0;
    md = eswi_mode_type'(7'h08);
    cmdV = 1'b0;
    cmd = 3'h0;
    wakePin = 1'b0;
    busLevel = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    waitc(1);
    `CHK(rxdHigh, 1'b1)
    `CHK(inhibit_output, 1'b1)
    chk_rd(ADDR_GLOBAL, 8'h00);
    chk_rd(ADDR_SYS, FLAGS_RST);
    chk_rd(8'h62, 8'h00);
    // power-on always captured, pin alerts while offline
    pulse(8'h80);
    waitc(2);
    `CHK(rxdHigh, 1'b0)
    chk_rd(ADDR_SYS, 8'h10);
    chk_rd(ADDR_SYS, 8'h10);
    chk_rd(ADDR_GLOBAL, 8'h01);
    @(posedge clk_sys);
    en.canWakeEn <= 1'b1;
    mode_cmd(CMD_SLEEP);
    `CHK({sleepEnter, standbyEnter}, 2'b01)
    i_host.wr(ADDR_SYS, 8'h00);
    chk_rd(ADDR_SYS, 8'h10);
    // clear releases pin; event in the delay waits for expiry
    i_host.wr(ADDR_SYS, 8'h10);
    `CHK(rxdHigh, 1'b1)
    pulse(8'h10);
    waitc(RD - 3);
    `CHK(rxdHigh, 1'b1)
    waitc(3);
    `CHK(rxdHigh, 1'b0)
    chk_rd(ADDR_TRX, 8'h20);
    chk_rd(ADDR_GLOBAL, 8'h04);
    // a second clear restarts the delay
    i_host.wr(ADDR_TRX, 8'h20);
    pulse(8'h10);
    i_host.wr(ADDR_TRX, 8'h01);
    waitc(RD - 1);
    `CHK(rxdHigh, 1'b1)
    waitc(3);
    `CHK(rxdHigh, 1'b0)
    i_host.clear_seen(ADDR_TRX);
    waitc(RD + 3);
    `CHK(rxdHigh, 1'b1)
    // capture enables and failure arming
    @(posedge clk_sys);
    md <= eswi_mode_type'({4'h8, 1'b1, TMC_ACTIVE});
    pulse(8'h60);
    chk_rd(ADDR_SYS, 8'h00);
    @(posedge clk_sys);
    en <= eswi_en_type'(7'h6c);
    pulse(8'h60);
    chk_rd(ADDR_SYS, 8'h06);
    pulse(8'h02);
    chk_rd(ADDR_TRX, 8'h02);
    i_host.wr(ADDR_TRX, 8'h02);
    @(posedge clk_sys);
    md.transceiver_mode_control <= 2'h0;
    pulse(8'h02);
    chk_rd(ADDR_TRX, 8'h00);
    pulse(8'h04);
    chk_rd(ADDR_TRX, 8'h02);
    @(posedge clk_sys);
    md.modeNormal <= 1'b0;
    i_host.wr(ADDR_TRX, 8'hff);
    pulse(8'h04);
    chk_rd(ADDR_TRX, 8'h00);
    i_host.wr(ADDR_SYS, 8'h06);
    chk_rd(ADDR_SYS, 8'h00);
    // bus silence after a full quiet period
    @(posedge clk_sys);
    en.silenceEn <= 1'b1;
    busLevel <= 1'b1;
    waitc(SP / 2);
    chk_rd(ADDR_TRX, 8'h00);
    waitc(SP);
    chk_rd(ADDR_TRX, 8'h10);
    @(posedge clk_sys);
    en.silenceEn <= 1'b0;
    i_host.wr(ADDR_TRX, 8'h10);
    // wake pin edges
    @(posedge clk_sys);
    en.wakeRiseEn <= 1'b1;
    en.wakeFallEn <= 1'b1;
    wakePin <= 1'b1;
    waitc(5);
    chk_rd(ADDR_WAKE, 8'h02);
    @(posedge clk_sys);
    wakePin <= 1'b0;
    waitc(5);
    chk_rd(ADDR_WAKE, 8'h03);
    chk_rd(ADDR_GLOBAL, 8'h08);
    i_host.clear_seen(ADDR_WAKE);
    chk_rd(ADDR_WAKE, 8'h00);
    // sleep protection: another code, no wake source, then granted
    mode_cmd(3'h2);
    `CHK({sleepEnter, standbyEnter}, 2'b00)
    @(posedge clk_sys);
    en <= '0;
    mode_cmd(CMD_SLEEP);
    `CHK({sleepEnter, standbyEnter}, 2'b01)
    @(posedge clk_sys);
    en <= eswi_en_type'(7'h24);
    mode_cmd(CMD_SLEEP);
    `CHK({sleepEnter, standbyEnter}, 2'b10)
    `CHK(inhibit_output, 1'b0)
    // in sleep a serial failure does not wake, a CAN wake-up does
    @(posedge clk_sys);
    md <= eswi_mode_type'(7'h10);
    pulse(8'h20);
    `CHK(wakeToStandby, 1'b0)
    `CHK(inhibit_output, 1'b0)
    pulse(8'h08);
    `CHK(wakeToStandby, 1'b1)
    `CHK(inhibit_output, 1'b1)
    // forced sleep clears only the power-on flag
    pulse(8'h80);
    chk_rd(ADDR_SYS, 8'h12);
    pulse(8'h01);
    chk_rd(ADDR_SYS, 8'h02);
    // pending flags stay silent in sleep, alert once in standby
    `CHK(rxdHigh, 1'b1)
    @(posedge clk_sys);
    md <= eswi_mode_type'(7'h20);
    waitc(3);
    `CHK(rxdHigh, 1'b0)
    conclude;
  end
endmodule
